//--- ccrb_regs.vh
// register map, field positions, reset values and frame layout of the codec control bank
`ifndef CCRB_REGS_VH
`define CCRB_REGS_VH
`define CCRB_ADDR_DAC_CTL_ONE 4'h0
`define CCRB_ADDR_DAC_CTL_TWO 4'h1
`define CCRB_ADDR_GAIN_FIRST 4'h2
`define CCRB_ADDR_GAIN_LAST 4'h9
`define CCRB_ADDR_LEFT_PEAK 4'hA
`define CCRB_ADDR_RIGHT_PEAK 4'hB
`define CCRB_ADDR_IN_CTL_ONE 4'hC
`define CCRB_ADDR_IN_CTL_TWO 4'hD
`define CCRB_ADDR_IN_CTL_THREE 4'hE
`define CCRB_ADDR_RESERVED 4'hF
`define CCRB_CTL_RESET 10'h000
`define CCRB_GAIN_RESET 10'h3FF
`define CCRB_PEAK_RESET 6'h00
`define CCRB_FRAME_ADDR_HI 15
`define CCRB_FRAME_ADDR_LO 12
`define CCRB_FRAME_RW_BIT 11
`define CCRB_FRAME_DATA_HI 9
`define CCRB_DEEMPH_HI 9
`define CCRB_DEEMPH_LO 8
`define CCRB_FORMAT_HI 7
`define CCRB_FORMAT_LO 5
`define CCRB_WIDTH_HI 4
`define CCRB_WIDTH_LO 3
`define CCRB_POWER_DOWN_BIT 2
`define CCRB_RATE_HI 1
`define CCRB_RATE_LO 0
`define CCRB_REPLICATE_BIT 8
`define CCRB_PEAK_ENABLE_BIT 5
`define CCRB_PEAK_FIELD_LO 4
`endif

//--- ccrb_frame_shifter.v
// serial control frame receiver and readback shifter
`timescale 1ns/100ps
`default_nettype none
module ccrb_frame_shifter #(
  parameter FRAME_BITS = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire sel_n_sync_i,
  input wire sclk_sync_i,
  input wire sdin_sync_i,
  input wire [9:0] read_data_i,
  output reg [FRAME_BITS-1:0] frame_o,
  output reg frame_done_o,
  output reg [3:0] read_addr_o,
  output reg read_addr_valid_o,
  output reg sdout_o
);
  reg sclk_prev_reg;
  reg [4:0] count_reg;
  reg [FRAME_BITS-1:0] shift_reg;
  reg [9:0] out_reg;
  reg read_dir_reg;
  wire rise = sclk_sync_i & ~sclk_prev_reg;
  wire fall = ~sclk_sync_i & sclk_prev_reg;
  wire [FRAME_BITS-1:0] shifted = {shift_reg[FRAME_BITS-2:0], sdin_sync_i};
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_prev_reg <= 1'b0;
      count_reg <= 5'h00;
      shift_reg <= {FRAME_BITS{1'b0}};
      out_reg <= 10'h000;
      frame_o <= {FRAME_BITS{1'b0}};
      frame_done_o <= 1'b0;
      read_addr_o <= 4'h0;
      read_addr_valid_o <= 1'b0;
      read_dir_reg <= 1'b0;
      sdout_o <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= sclk_sync_i;
      frame_done_o <= 1'b0;
      read_addr_valid_o <= 1'b0;
      if (sel_n_sync_i)
      begin
        // deselect aborts a partial frame
        count_reg <= 5'h00;
        sdout_o <= 1'b0;
      end
      else
      begin
        if (rise && count_reg < FRAME_BITS)
        begin
          shift_reg <= shifted;
          count_reg <= count_reg + 5'h01;
          // five bits carry address and direction, ahead of the readback latch at bit six
          if (count_reg == 5'h04)
          begin
            read_addr_o <= shifted[4:1];
            read_dir_reg <= shifted[0];
          end
          if (count_reg == 5'h0F)
          begin
            frame_o <= shifted;
            frame_done_o <= 1'b1;
          end
        end
        // data bits 9..0 leave msb first on falling edges
        // the peak clear follows the latch, so a read reports the peak up to now
        if (fall && count_reg == 5'h06)
        begin
          out_reg <= read_data_i;
          read_addr_valid_o <= read_dir_reg;
        end
        if (fall && count_reg >= 5'h06 && count_reg < FRAME_BITS)
        begin
          sdout_o <= (count_reg == 5'h06) ? read_data_i[9] : out_reg[8];
          if (count_reg != 5'h06)
            out_reg <= {out_reg[8:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- ccrb_peak_holder.v
// one channel of peak capture held as attenuation, cleared by readback
`timescale 1ns/100ps
`default_nettype none
`include "ccrb_regs.vh"
module ccrb_peak_holder (
  input wire clk_i,
  input wire rst_i,
  input wire enable_i,
  input wire sample_valid_i,
  input wire [5:0] atten_i,
  input wire read_clear_i,
  output reg [5:0] peak_o
);
  reg seen_reg;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      peak_o <= `CCRB_PEAK_RESET;
      seen_reg <= 1'b0;
    end
    // a sample arriving with the clear starts the new interval
    else if (read_clear_i)
    begin
      peak_o <= (enable_i && sample_valid_i) ? atten_i : `CCRB_PEAK_RESET;
      seen_reg <= enable_i & sample_valid_i;
    end
    // smaller attenuation is a louder peak
    else if (enable_i && sample_valid_i && (!seen_reg || atten_i < peak_o))
    begin
      peak_o <= atten_i;
      seen_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- ccrb_control_bank.v
// control and status register bank of the six-output codec, reached by serial frames
`timescale 1ns/100ps
`default_nettype none
`include "ccrb_regs.vh"
module ccrb_control_bank #(
  parameter SAMPLE_BITS = 24
) (
  input wire clk_i,
  input wire rst_i,
  input wire sel_n_i,
  input wire sclk_i,
  input wire sdin_i,
  output wire sdout_o,
  input wire peak_sample_valid_i,
  input wire [5:0] left_atten_i,
  input wire [5:0] right_atten_i,
  input wire [SAMPLE_BITS-1:0] pair_one_left_i,
  input wire [SAMPLE_BITS-1:0] pair_one_right_i,
  input wire [SAMPLE_BITS-1:0] pair_two_left_i,
  input wire [SAMPLE_BITS-1:0] pair_two_right_i,
  input wire [SAMPLE_BITS-1:0] pair_three_left_i,
  input wire [SAMPLE_BITS-1:0] pair_three_right_i,
  output reg [SAMPLE_BITS-1:0] out_one_left_o,
  output reg [SAMPLE_BITS-1:0] out_one_right_o,
  output reg [SAMPLE_BITS-1:0] out_two_left_o,
  output reg [SAMPLE_BITS-1:0] out_two_right_o,
  output reg [SAMPLE_BITS-1:0] out_three_left_o,
  output reg [SAMPLE_BITS-1:0] out_three_right_o,
  output wire [1:0] deemphasis_o,
  output wire [2:0] serial_format_o,
  output wire [1:0] word_width_o,
  output wire power_down_o,
  output wire [1:0] rate_select_o,
  output wire interp_4x_o,
  output wire interp_2x_o,
  output wire stereo_replicate_o,
  output wire left_out_one_silence_o,
  output wire right_out_one_silence_o,
  output wire left_out_two_silence_o,
  output wire right_out_two_silence_o,
  output wire left_out_three_silence_o,
  output wire right_out_three_silence_o,
  output wire [79:0] gains_o,
  output wire [9:0] in_control_one_o,
  output wire [9:0] in_control_two_o,
  output wire [9:0] in_control_three_o
);
  reg sel_n_meta_reg;
  reg sel_n_sync_reg;
  reg sclk_meta_reg;
  reg sclk_sync_reg;
  reg sdin_meta_reg;
  reg sdin_sync_reg;
  reg [9:0] dac_control_one_reg;
  reg [9:0] dac_control_two_reg;
  reg [9:0] converter_in_control_one_reg;
  reg [9:0] converter_in_control_two_reg;
  reg [9:0] converter_in_control_three_reg;
  reg [9:0] gain_reg [0:7];
  reg [9:0] read_data;
  wire [15:0] frame;
  wire frame_done;
  wire [3:0] read_addr;
  wire read_addr_valid;
  wire [5:0] left_peak_level;
  wire [5:0] right_peak_level;
  wire [3:0] wr_addr = frame[`CCRB_FRAME_ADDR_HI:`CCRB_FRAME_ADDR_LO];
  wire wr_en = frame_done & ~frame[`CCRB_FRAME_RW_BIT];
  wire [9:0] wr_data = frame[`CCRB_FRAME_DATA_HI:0];
  wire peak_enable = converter_in_control_three_reg[`CCRB_PEAK_ENABLE_BIT];
  wire read_left = read_addr_valid && read_addr == `CCRB_ADDR_LEFT_PEAK;
  wire read_right = read_addr_valid && read_addr == `CCRB_ADDR_RIGHT_PEAK;
  wire replicate = dac_control_two_reg[`CCRB_REPLICATE_BIT];
  // one strobe per writable control slot; peak and reserved slots have none
  wire wr_dac_one = wr_en && wr_addr == `CCRB_ADDR_DAC_CTL_ONE;
  wire wr_dac_two = wr_en && wr_addr == `CCRB_ADDR_DAC_CTL_TWO;
  wire wr_in_one = wr_en && wr_addr == `CCRB_ADDR_IN_CTL_ONE;
  wire wr_in_two = wr_en && wr_addr == `CCRB_ADDR_IN_CTL_TWO;
  wire wr_in_three = wr_en && wr_addr == `CCRB_ADDR_IN_CTL_THREE;
  // replicate source select
  // pairs two and three drop their own data while replicate is on
  wire [SAMPLE_BITS-1:0] src_two_left = replicate ? pair_one_left_i : pair_two_left_i;
  wire [SAMPLE_BITS-1:0] src_two_right = replicate ? pair_one_right_i : pair_two_right_i;
  wire [SAMPLE_BITS-1:0] src_three_left = replicate ? pair_one_left_i : pair_three_left_i;
  wire [SAMPLE_BITS-1:0] src_three_right = replicate ? pair_one_right_i : pair_three_right_i;
  // pins are asynchronous to clk_i: two flops before any use
  // three clocks of latency, hence the minimum serial phase length
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_n_meta_reg <= 1'b1;
      sel_n_sync_reg <= 1'b1;
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sdin_meta_reg <= 1'b0;
      sdin_sync_reg <= 1'b0;
    end
    else
    begin
      sel_n_meta_reg <= sel_n_i;
      sel_n_sync_reg <= sel_n_meta_reg;
      sclk_meta_reg <= sclk_i;
      sclk_sync_reg <= sclk_meta_reg;
      sdin_meta_reg <= sdin_i;
      sdin_sync_reg <= sdin_meta_reg;
    end
  end
  ccrb_frame_shifter #(
    .FRAME_BITS(16)
  ) u_shifter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_n_sync_i(sel_n_sync_reg),
    .sclk_sync_i(sclk_sync_reg),
    .sdin_sync_i(sdin_sync_reg),
    .read_data_i(read_data),
    .frame_o(frame),
    .frame_done_o(frame_done),
    .read_addr_o(read_addr),
    .read_addr_valid_o(read_addr_valid),
    .sdout_o(sdout_o)
  );
  // clear pulses arrive only once the readback word has been latched
  // capture enable
  ccrb_peak_holder u_left_peak (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(peak_enable),
    .sample_valid_i(peak_sample_valid_i),
    .atten_i(left_atten_i),
    .read_clear_i(read_left),
    .peak_o(left_peak_level)
  );
  ccrb_peak_holder u_right_peak (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(peak_enable),
    .sample_valid_i(peak_sample_valid_i),
    .atten_i(right_atten_i),
    .read_clear_i(read_right),
    .peak_o(right_peak_level)
  );
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac_control_one_reg <= `CCRB_CTL_RESET;
      dac_control_two_reg <= `CCRB_CTL_RESET;
      converter_in_control_one_reg <= `CCRB_CTL_RESET;
      converter_in_control_two_reg <= `CCRB_CTL_RESET;
      converter_in_control_three_reg <= `CCRB_CTL_RESET;
    end
    else
    begin
      if (wr_dac_one)
        dac_control_one_reg <= wr_data;
      if (wr_dac_two)
        dac_control_two_reg <= wr_data;
      if (wr_in_one)
        converter_in_control_one_reg <= wr_data;
      if (wr_in_two)
        converter_in_control_two_reg <= wr_data;
      if (wr_in_three)
        converter_in_control_three_reg <= wr_data;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : gen_gain
      wire gain_hit = wr_en && wr_addr == `CCRB_ADDR_GAIN_FIRST + g;
      always @(posedge clk_i)
      begin
        if (rst_i)
          gain_reg[g] <= `CCRB_GAIN_RESET;
        else if (gain_hit)
          gain_reg[g] <= wr_data;
      end
      assign gains_o[g*10+9:g*10] = gain_reg[g];
    end
  endgenerate
  // the shifter latches this word on the falling edge after bit six
  // peak slots read-only
  always @*
  begin
    read_data = 10'h000;
    case (read_addr)
      `CCRB_ADDR_DAC_CTL_ONE: read_data = dac_control_one_reg;
      `CCRB_ADDR_DAC_CTL_TWO: read_data = dac_control_two_reg;
      `CCRB_ADDR_LEFT_PEAK: read_data = {left_peak_level, 4'h0};
      `CCRB_ADDR_RIGHT_PEAK: read_data = {right_peak_level, 4'h0};
      `CCRB_ADDR_IN_CTL_ONE: read_data = converter_in_control_one_reg;
      `CCRB_ADDR_IN_CTL_TWO: read_data = converter_in_control_two_reg;
      `CCRB_ADDR_IN_CTL_THREE: read_data = converter_in_control_three_reg;
      `CCRB_ADDR_RESERVED: read_data = 10'h000;
      `CCRB_ADDR_GAIN_FIRST: read_data = gain_reg[0];
      `CCRB_ADDR_GAIN_FIRST + 4'h1: read_data = gain_reg[1];
      `CCRB_ADDR_GAIN_FIRST + 4'h2: read_data = gain_reg[2];
      `CCRB_ADDR_GAIN_FIRST + 4'h3: read_data = gain_reg[3];
      `CCRB_ADDR_GAIN_FIRST + 4'h4: read_data = gain_reg[4];
      `CCRB_ADDR_GAIN_FIRST + 4'h5: read_data = gain_reg[5];
      `CCRB_ADDR_GAIN_FIRST + 4'h6: read_data = gain_reg[6];
      `CCRB_ADDR_GAIN_LAST: read_data = gain_reg[7];
      default: read_data = 10'h000;
    endcase
  end
  assign deemphasis_o = dac_control_one_reg[`CCRB_DEEMPH_HI:`CCRB_DEEMPH_LO];
  assign serial_format_o = dac_control_one_reg[`CCRB_FORMAT_HI:`CCRB_FORMAT_LO];
  assign word_width_o = dac_control_one_reg[`CCRB_WIDTH_HI:`CCRB_WIDTH_LO];
  assign power_down_o = dac_control_one_reg[`CCRB_POWER_DOWN_BIT];
  assign rate_select_o = dac_control_one_reg[`CCRB_RATE_HI:`CCRB_RATE_LO];
  assign interp_4x_o = rate_select_o == 2'b01;
  assign interp_2x_o = rate_select_o == 2'b10;
  assign stereo_replicate_o = replicate;
  assign left_out_one_silence_o = dac_control_two_reg[0];
  assign right_out_one_silence_o = dac_control_two_reg[1];
  assign left_out_two_silence_o = dac_control_two_reg[2];
  assign right_out_two_silence_o = dac_control_two_reg[3];
  assign left_out_three_silence_o = dac_control_two_reg[4];
  assign right_out_three_silence_o = dac_control_two_reg[5];
  assign in_control_one_o = converter_in_control_one_reg;
  assign in_control_two_o = converter_in_control_two_reg;
  assign in_control_three_o = converter_in_control_three_reg;
  // replicate routing
  // pair one always plays its own data
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_one_left_o <= {SAMPLE_BITS{1'b0}};
      out_one_right_o <= {SAMPLE_BITS{1'b0}};
    end
    else
    begin
      out_one_left_o <= pair_one_left_i;
      out_one_right_o <= pair_one_right_i;
    end
  end
  // pairs two and three follow their selected source one clock later
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_two_left_o <= {SAMPLE_BITS{1'b0}};
      out_two_right_o <= {SAMPLE_BITS{1'b0}};
    end
    else
    begin
      out_two_left_o <= src_two_left;
      out_two_right_o <= src_two_right;
    end
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_three_left_o <= {SAMPLE_BITS{1'b0}};
      out_three_right_o <= {SAMPLE_BITS{1'b0}};
    end
    else
    begin
      out_three_left_o <= src_three_left;
      out_three_right_o <= src_three_right;
    end
  end
endmodule
`default_nettype wire

//--- ccrb_control_bank_checker.sv
// assertions on the ports of the codec control bank
`timescale 1ns/100ps
`default_nettype none
module ccrb_checker #(
  parameter SAMPLE_BITS = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sel_n_i,
  input wire logic sdout_o,
  input wire logic [SAMPLE_BITS-1:0] pair_one_left_i,
  input wire logic [SAMPLE_BITS-1:0] pair_two_left_i,
  input wire logic [SAMPLE_BITS-1:0] out_one_left_o,
  input wire logic [SAMPLE_BITS-1:0] out_two_left_o,
  input wire logic [1:0] rate_select_o,
  input wire logic interp_4x_o,
  input wire logic interp_2x_o,
  input wire logic stereo_replicate_o,
  input wire logic power_down_o,
  input wire logic [79:0] gains_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_OUT_ONE:
    assert property (!$past(rst_i) |-> out_one_left_o == $past(pair_one_left_i)) else $error("pair one lost");
  AST_RPL_ON:
    assert property (!$past(rst_i) && $past(stereo_replicate_o) |-> out_two_left_o == $past(pair_one_left_i))
      else $error("replicate not applied");
  AST_RPL_OFF:
    assert property (!$past(rst_i) && !$past(stereo_replicate_o) |-> out_two_left_o == $past(pair_two_left_i))
      else $error("pair two lost");
  AST_RATE_4X:
    assert property (interp_4x_o == (rate_select_o == 2'h1)) else $error("4x decode wrong");
  AST_RATE_2X:
    assert property (interp_2x_o == (rate_select_o == 2'h2)) else $error("2x decode wrong");
  AST_SDOUT_IDLE:
    assert property (sel_n_i [*6] |-> !sdout_o) else $error("readback line busy when idle");
  AST_HOLD:
    assert property (sel_n_i [*8] |=> $stable(gains_o) && $stable(power_down_o) && $stable(stereo_replicate_o))
      else $error("register changed outside a frame");
  AST_RESET:
    assert property (disable iff (1'h0) rst_i |=> gains_o == {8{10'h3FF}} && !power_down_o && !stereo_replicate_o)
      else $error("reset values wrong");
endmodule
bind ccrb_control_bank ccrb_checker #(.SAMPLE_BITS(SAMPLE_BITS)) u_chk (.clk_i, .rst_i, .sel_n_i, .sdout_o,
  .pair_one_left_i, .pair_two_left_i, .out_one_left_o, .out_two_left_o, .rate_select_o, .interp_4x_o,
  .interp_2x_o, .stereo_replicate_o, .power_down_o, .gains_o);
`default_nettype wire

//--- ccrb_host.sv
// host controller model sending serial control frames
`timescale 1ns/100ps
`default_nettype none
module ccrb_host (
  input wire logic clk_i,
  input wire logic sdout_i,
  output logic sel_n_o,
  output logic sclk_o,
  output logic sdin_o
);
  // each serial clock phase spans 6 clk, above the 3 clk the synchronisers need
  localparam int PH = 6;
  initial
  begin
    sel_n_o = 1'h1;
    sclk_o = 1'h0;
    sdin_o = 1'h0;
  end
  task automatic xfer(input logic [3:0] a, input logic rd, input logic [9:0] d, output logic [9:0] q);
    logic [15:0] f;
    f = {a, rd, 1'h0, rd ? 10'h000 : d};
    q = 10'h000;
    sel_n_o = 1'h0;
    repeat (PH) @(negedge clk_i);
    for (int i = 15; i >= 0; i--)
    begin
      sdin_o = f[i];
      repeat (PH) @(negedge clk_i);
      // readback taken before the rising edge
      if (i < 10)
        q[i] = sdout_i;
      sclk_o = 1'h1;
      repeat (PH) @(negedge clk_i);
      sclk_o = 1'h0;
    end
    repeat (PH) @(negedge clk_i);
    sel_n_o = 1'h1;
    // released data line must not keep its last level
    sdin_o = ~sdin_o;
    repeat (PH) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the codec control bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic pv = 1'h0;
  logic go = 1'h0;
  logic rp = 1'h0;
  logic [5:0] la = 6'h00;
  logic [5:0] ra = 6'h00;
  logic [23:0] p [6] = '{default: 24'h00_0000};
  logic [31:0] seed = 32'h0000_0041;
  logic [31:0] r;
  logic [31:0] rr;
  logic [9:0] q;
  logic [9:0] mdl [16];
  logic [1:0] pk_seen = 2'h0;
  int n_mismatch = 0;
  int num_checks = 0;
  wire sel_n, sclk, sdin, sdout, pd, i4, i2, rep;
  wire [23:0] o [6];
  wire [1:0] deemph, width, rate;
  wire [2:0] fmt;
  wire [5:0] sil;
  wire [79:0] gains;
  wire [9:0] ic1, ic2, ic3;
  always #20 clk_i = ~clk_i;
  ccrb_host host (.clk_i(clk_i), .sdout_i(sdout), .sel_n_o(sel_n), .sclk_o(sclk), .sdin_o(sdin));
  ccrb_control_bank #(.SAMPLE_BITS(24)) dut (.clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n), .sclk_i(sclk),
    .sdin_i(sdin), .sdout_o(sdout), .peak_sample_valid_i(pv), .left_atten_i(la), .right_atten_i(ra),
    .pair_one_left_i(p[0]), .pair_one_right_i(p[1]), .pair_two_left_i(p[2]), .pair_two_right_i(p[3]),
    .pair_three_left_i(p[4]), .pair_three_right_i(p[5]), .out_one_left_o(o[0]), .out_one_right_o(o[1]),
    .out_two_left_o(o[2]), .out_two_right_o(o[3]), .out_three_left_o(o[4]), .out_three_right_o(o[5]),
    .deemphasis_o(deemph), .serial_format_o(fmt), .word_width_o(width), .power_down_o(pd),
    .rate_select_o(rate), .interp_4x_o(i4), .interp_2x_o(i2), .stereo_replicate_o(rep),
    .left_out_one_silence_o(sil[0]), .right_out_one_silence_o(sil[1]), .left_out_two_silence_o(sil[2]),
    .right_out_two_silence_o(sil[3]), .left_out_three_silence_o(sil[4]), .right_out_three_silence_o(sil[5]),
    .gains_o(gains), .in_control_one_o(ic1), .in_control_two_o(ic2), .in_control_three_o(ic3));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    host.xfer(a, 1'h0, d, q);
    // peak and reserved slots ignore writes
    if (a < 4'hA || (a > 4'hB && a != 4'hF))
      mdl[a] = d;
  endtask
  task automatic rdchk(input logic [3:0] a);
    host.xfer(a, 1'h1, 10'h000, q);
    chk(q, mdl[a]);
    // a peak read starts a new interval
    if (a == 4'hA || a == 4'hB)
    begin
      mdl[a] = 10'h000;
      pk_seen[a[0]] = 1'h0;
    end
  endtask
  // one attenuation sample per channel, presented for a single clock
  task automatic feed(input logic [5:0] l, input logic [5:0] r);
    pv = 1'h1;
    la = l;
    ra = r;
    @(negedge clk_i);
    pv = 1'h0;
    // capture only while enabled; smaller attenuation is the louder peak
    if (mdl[14][5])
    begin
      if (!pk_seen[0] || l < mdl[10][9:4])
        mdl[10] = {l, 4'h0};
      if (!pk_seen[1] || r < mdl[11][9:4])
        mdl[11] = {r, 4'h0};
      pk_seen = 2'h3;
    end
  endtask
  task automatic dec();
    chk({deemph, fmt, width, pd, rate}, mdl[0]);
    chk({i4, i2}, {mdl[0][1:0] == 2'h1, mdl[0][1:0] == 2'h2});
    chk({rep, sil}, {mdl[1][8], mdl[1][5:0]});
    chk(gains, {mdl[9], mdl[8], mdl[7], mdl[6], mdl[5], mdl[4], mdl[3], mdl[2]});
    chk({ic3, ic2, ic1}, {mdl[14], mdl[13], mdl[12]});
  endtask
  // output samples follow their pair one cycle later
  always @(negedge clk_i)
  begin
    if (go)
      for (int j = 0; j < 6; j++)
        chk(o[j], rp ? p[j % 2] : p[j]);
    rp = rep;
    for (int j = 0; j < 6; j++)
    begin
      rr = rnd();
      p[j] = rr[23:0];
    end
  end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end
  initial
  begin
    for (int i = 0; i < 16; i++)
      mdl[i] = (i > 1 && i < 10) ? 10'h3FF : 10'h000;
    repeat (2) @(negedge clk_i);
    rst_i = 1'h0;
    repeat (4) @(negedge clk_i);
    go = 1'h1;
    for (int i = 0; i < 16; i++)
      rdchk(i[3:0]);
    dec();
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h0, {i[1:0], i[2:0], i[1:0], i[0], i[1:0]});
      dec();
    end
    for (int k = 0; k < 3; k++)
    begin
      for (int i = 0; i < 16; i++)
      begin
        r = rnd();
        wr(i[3:0], r[9:0]);
      end
      for (int i = 0; i < 16; i++)
        rdchk(i[3:0]);
      dec();
    end
    wr(4'h1, 10'h100);
    dec();
    wr(4'hE, 10'h000);
    feed(6'h05, 6'h2A);
    rdchk(4'hA);
    wr(4'hE, 10'h020);
    for (int k = 0; k < 3; k++)
    begin
      for (int m = 0; m < 3; m++)
      begin
        r = rnd();
        feed(r[5:0], r[13:8]);
      end
      rdchk(4'hA);
      rdchk(4'hB);
    end
    feed(6'h3F, 6'h00);
    rdchk(4'hA);
    rdchk(4'hA);
    rdchk(4'hB);
    close_out();
  end
endmodule
`default_nettype wire
